/* rtl/vfdom_defines.svh */
// Constants for the output map port and the filament bridge generator
// Contract
// - Reset loads map 0x00-0x27 with codes 0-39, and 0x72-0x79 with 127.
// - Reset loads map 0x28-0x4B with consecutive codes 48 to 83.
// - Reset loads map 0x4C-0x6F with consecutive codes 84 to 119.
// - Reset loads map 0x70 with code 124 and 0x71 with code 125.
// - Write to 0x06 with bit 7 set loads the pointer from bits 6:0.
// - The map pointer is zero after reset.
// - Write to 0x06 with bit 7 clear stores seven bits, then advances pointer.
// - Read at 0x86 returns bit 7 zero plus pointed data, then advances pointer.
// - Both legs low for 199 minus on-count ticks at period start and end.
// - Second interval drives leg B high, leg A low, for on-count ticks.
// - Fourth interval drives leg A high, leg B low, for on-count ticks.
// - On-count is an 8-bit write to 0x09, valid from 1 to 199.
// - Bits 1:0 at 0x0A: 00 drives leg A pin 0 (reset), 01 drives 1.
// - Code 10 makes the pin show the blink phase, 0 first, 1 second.
// - Code 11 gives the leg A waveform, forced low in shutdown.
// - Register 0x0B configures leg B pin alike; code 11 gives leg B waveform.
// - Codes 0-47 select grids, 124 lower cursor, 126 and 127 do nothing.
`ifndef VFDOM_DEFINES_SVH
`define VFDOM_DEFINES_SVH

// Command addresses, bit 7 of the address selects read
`define CMD_READ_BIT 7
`define REG_OUTPUT_MAP_PORT 7'h06
`define REG_FILAMENT_DUTY 7'h09
`define REG_FIRST_PHASE_CFG 7'h0A
`define REG_SECOND_PHASE_CFG 7'h0B

// Map port fields and limits
`define MAP_PTR_LOAD_BIT 7
`define MAP_LAST 7'h79
`define MAP_GRID_END 7'h27
`define MAP_SEG_END 7'h6F
`define MAP_CURSOR_LO_ADDR 7'h70
`define MAP_CURSOR_HI_ADDR 7'h71
`define MAP_SEG_OFFSET 7'h08
`define CODE_GRID_LAST 7'h2F
`define CODE_CURSOR_LO 7'h7C
`define CODE_CURSOR_HI 7'h7D
`define CODE_NONE_FIRST 7'h7E
`define CODE_NO_ACTION 7'h7F

// Reset values
`define FIL_ON_RST 8'h01
`define PIN_CFG_RST 2'h0

// Filament timing, ticks of the internal oscillator
`define SYS_CLK_HZ 50000000
`define FIL_TICK_HZ 4000000
`define FIL_PERIOD_US 100
`define FIL_PERIOD_TICKS ((`FIL_PERIOD_US * `FIL_TICK_HZ) / 1000000)
`define FIL_ON_MIN 8'h01
`define FIL_ON_MAX 8'hC7
`define FIL_DEAD_TICKS 2
`define FIL_B_END 9'h0C7
`define FIL_A_START 9'h0C9

`endif

/* rtl/vfdom_pkg.sv */
// Types shared by the output map and filament blocks
package vfdom_pkg;
	// Pin configuration codes for both bridge leg pins
	typedef enum logic [1:0] {
		PIN_LOW = 2'h0,
		PIN_HIGH = 2'h1,
		PIN_BLINK = 2'h2,
		PIN_FILAMENT = 2'h3
	} vfdom_pin_mode_t;

	// Map location index and map code
	typedef logic [6:0] vfdom_map_addr_t;
	typedef logic [6:0] vfdom_map_code_t;
endpackage

/* rtl/vfdom_map_if.sv */
// Connection between the command decoder and the output map memory
`timescale 1ns/1ps
interface vfdom_map_if;
	logic wr_en;
	vfdom_pkg::vfdom_map_addr_t wr_addr;
	vfdom_pkg::vfdom_map_code_t wr_data;
	vfdom_pkg::vfdom_map_addr_t rd_addr;
	vfdom_pkg::vfdom_map_code_t rd_data;
	vfdom_pkg::vfdom_map_addr_t lk_addr;
	vfdom_pkg::vfdom_map_code_t lk_data;

	modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, lk_addr, input rd_data, lk_data);
	modport mem (input wr_en, wr_addr, wr_data, rd_addr, lk_addr, output rd_data, lk_data);
endinterface

/* rtl/vfdom_map_ram.sv */
// Output map memory with its reset contents
`timescale 1ns/1ps
`include "vfdom_defines.svh"
module vfdom_map_ram (
	// Clock and reset
	input logic ref_clk_in,
	input logic rstn_in,
	// Map access
	vfdom_map_if.mem bus
);
	localparam int DEPTH = 122;

	logic [6:0] mem_q [0:DEPTH-1];

	// Reset contents of one location
	function automatic logic [6:0] init_code(input logic [6:0] idx);
		if (idx <= `MAP_GRID_END) begin
			init_code = idx;
		end else if (idx <= `MAP_SEG_END) begin
			init_code = 7'(idx + `MAP_SEG_OFFSET);
		end else if (idx == `MAP_CURSOR_LO_ADDR) begin
			init_code = `CODE_CURSOR_LO;
		end else if (idx == `MAP_CURSOR_HI_ADDR) begin
			init_code = `CODE_CURSOR_HI;
		end else begin
			init_code = `CODE_NO_ACTION;
		end
	endfunction

	// Reset load and host writes; addresses past the end are dropped
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= init_code(7'(i));
			end
		end else if (bus.wr_en && bus.wr_addr <= `MAP_LAST) begin
			mem_q[bus.wr_addr] <= bus.wr_data;
		end
	end

	// Read ports, unmapped locations read zero
	assign bus.rd_data = (bus.rd_addr <= `MAP_LAST) ? mem_q[bus.rd_addr] : 7'h00;
	assign bus.lk_data = (bus.lk_addr <= `MAP_LAST) ? mem_q[bus.lk_addr] : 7'h00;

	////////////////////////////////////////////////////////////////////////////
	// Checks on the reset contents
	chk_init_table: assert property (@(posedge ref_clk_in) $past(!rstn_in) && rstn_in |->
		mem_q[39] == 7'h27 && mem_q[40] == 7'h30 && mem_q[75] == 7'h53 && mem_q[76] == 7'h54 &&
		mem_q[111] == 7'h77 && mem_q[112] == 7'h7C && mem_q[113] == 7'h7D && mem_q[121] == 7'h7F)
		else $error("map reset contents wrong");
endmodule

/* rtl/vfdom_fil_gen.sv */
// Filament full-bridge waveform generator
`timescale 1ns/1ps
`include "vfdom_defines.svh"
module vfdom_fil_gen (
	// Clock and reset
	input logic ref_clk_in,
	input logic rstn_in,
	// Programmed on-count
	input logic [7:0] on_count_in,
	// Raw bridge waveforms
	output logic leg_a_out,
	output logic leg_b_out
);
	localparam logic [25:0] TICK_STEP = 26'(`FIL_TICK_HZ);
	localparam logic [25:0] CLK_MOD = 26'(`SYS_CLK_HZ);
	localparam logic [8:0] PERIOD_LAST = 9'(`FIL_PERIOD_TICKS - 1);

	logic [25:0] acc_q;
	logic tick;
	logic [8:0] pos_q;
	logic [7:0] on_q;
	logic [7:0] on_clamp;
	logic [8:0] a_len;
	logic leg_a_q;
	logic leg_b_q;
	logic [7:0] hb_q;

	// Fractional divider giving an average 4 MHz oscillator tick
	assign tick = (acc_q + TICK_STEP) >= CLK_MOD;
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			acc_q <= 26'h0000000;
		end else if (tick) begin
			acc_q <= 26'(acc_q + TICK_STEP - CLK_MOD);
		end else begin
			acc_q <= 26'(acc_q + TICK_STEP);
		end
	end

	// Out-of-range on-counts are held to the valid span
	always_comb begin
		if (on_count_in < `FIL_ON_MIN) begin
			on_clamp = `FIL_ON_MIN;
		end else if (on_count_in > `FIL_ON_MAX) begin
			on_clamp = `FIL_ON_MAX;
		end else begin
			on_clamp = on_count_in;
		end
	end

	// Period position, on-count sampled only at wrap
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			pos_q <= 9'h000;
			on_q <= `FIL_ON_RST;
		end else if (tick) begin
			if (pos_q >= PERIOD_LAST) begin
				pos_q <= 9'h000;
				on_q <= on_clamp;
			end else begin
				pos_q <= 9'(pos_q + 9'h001);
			end
		end
	end

	// Intervals A, B, C, D, E laid out on the position
	assign a_len = 9'(`FIL_B_END - {1'b0, on_q});
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			leg_a_q <= 1'b0;
			leg_b_q <= 1'b0;
		end else begin
			leg_b_q <= (pos_q >= a_len) && (pos_q < `FIL_B_END);
			leg_a_q <= (pos_q >= `FIL_A_START) && (pos_q < 9'(`FIL_A_START + {1'b0, on_q}));
		end
	end

	assign leg_a_out = leg_a_q;
	assign leg_b_out = leg_b_q;

	////////////////////////////////////////////////////////////////////////////
	// Helper: ticks counted while leg B is high
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in || !leg_b_q) begin
			hb_q <= 8'h00;
		end else if (tick) begin
			hb_q <= 8'(hb_q + 8'h01);
		end
	end

	chk_period_wrap: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		pos_q <= PERIOD_LAST and (tick && pos_q == PERIOD_LAST |=> pos_q == 9'h000))
		else $error("filament period not 400 ticks");
	chk_on_latch: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		$changed(on_q) |-> $past(tick) && $past(pos_q) == PERIOD_LAST)
		else $error("on-count changed mid period");
	chk_lead_low: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		$rose(leg_b_q) |-> $past(pos_q) == 9'(`FIL_B_END - {1'b0, on_q}))
		else $error("leading low interval wrong");
	chk_b_width: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		$fell(leg_b_q) |-> $past(hb_q) == on_q || hb_q == on_q)
		else $error("leg B width differs from on-count");
	chk_dead_time: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		!(leg_a_q && leg_b_q) and ($fell(leg_b_q) |-> $past(pos_q) == `FIL_B_END) and
		($rose(leg_a_q) |-> $past(pos_q) == `FIL_A_START))
		else $error("dead time broken");
	chk_a_drive: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		$rose(leg_a_q) |=> leg_a_q && !leg_b_q)
		else $error("leg A interval wrong");
	cov_period_end: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) tick && pos_q == PERIOD_LAST);
	cov_leg_a: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) $fell(leg_a_q));
endmodule

/* rtl/vfdom_top.sv */
// Output map command port and filament bridge pin drive
`timescale 1ns/1ps
`include "vfdom_defines.svh"
module vfdom_top (
	// Clock and reset
	input logic ref_clk_in,
	input logic rstn_in,
	// Command port
	input logic cmd_valid_in,
	input logic [7:0] cmd_addr_in,
	input logic [7:0] cmd_data_in,
	output logic rd_valid_out,
	output logic [7:0] rd_data_out,
	// Device state
	input logic shutdown_in,
	input logic blink_phase_in,
	// Map lookup for the display shifter
	input logic [6:0] map_lookup_addr_in,
	output logic [6:0] map_lookup_code_out,
	output logic map_lookup_grid_out,
	output logic map_lookup_cursor_out,
	output logic map_lookup_none_out,
	// Bridge pins
	output logic bridge_leg_a_out,
	output logic bridge_leg_b_out
);
	vfdom_map_if map_bus ();

	logic cmd_wr;
	logic cmd_rd;
	logic [6:0] cmd_reg;
	logic map_ptr_load;
	logic map_wr;
	logic map_rd;
	logic [6:0] ptr_q;
	logic [7:0] filament_on_count_q;
	vfdom_pkg::vfdom_pin_mode_t leg_a_cfg_q;
	vfdom_pkg::vfdom_pin_mode_t leg_b_cfg_q;
	logic rd_valid_q;
	logic [7:0] rd_data_q;
	logic fil_a;
	logic fil_b;
	logic leg_a_q;
	logic leg_b_q;
	logic [6:0] lk_code_q;
	logic lk_grid_q;
	logic lk_cursor_q;
	logic lk_none_q;

	////////////////////////////////////////////////////////////////////////////
	// Pointer advance, wrapping past the last location
	function automatic logic [6:0] next_ptr(input logic [6:0] p);
		next_ptr = (p >= `MAP_LAST) ? 7'h00 : 7'(p + 7'h01);
	endfunction

	// Pin level for a configuration code
	function automatic logic pin_level(input vfdom_pkg::vfdom_pin_mode_t mode, input logic blink,
		input logic wave, input logic sd);
		case (mode)
			vfdom_pkg::PIN_LOW: pin_level = 1'b0;
			vfdom_pkg::PIN_HIGH: pin_level = 1'b1;
			vfdom_pkg::PIN_BLINK: pin_level = blink;
			vfdom_pkg::PIN_FILAMENT: pin_level = wave && !sd;
			default: pin_level = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Command decode
	assign cmd_wr = cmd_valid_in && !cmd_addr_in[`CMD_READ_BIT];
	assign cmd_rd = cmd_valid_in && cmd_addr_in[`CMD_READ_BIT];
	assign cmd_reg = cmd_addr_in[6:0];
	assign map_ptr_load = cmd_wr && cmd_reg == `REG_OUTPUT_MAP_PORT && cmd_data_in[`MAP_PTR_LOAD_BIT];
	assign map_wr = cmd_wr && cmd_reg == `REG_OUTPUT_MAP_PORT && !cmd_data_in[`MAP_PTR_LOAD_BIT];
	assign map_rd = cmd_rd && cmd_reg == `REG_OUTPUT_MAP_PORT;

	// Map pointer
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			ptr_q <= 7'h00;
		end else if (map_ptr_load) begin
			ptr_q <= cmd_data_in[6:0];
		end else if (map_wr || map_rd) begin
			ptr_q <= next_ptr(ptr_q);
		end
	end

	// Map memory connection
	assign map_bus.wr_en = map_wr;
	assign map_bus.wr_addr = ptr_q;
	assign map_bus.wr_data = cmd_data_in[6:0];
	assign map_bus.rd_addr = ptr_q;
	assign map_bus.lk_addr = map_lookup_addr_in;

	vfdom_map_ram u_map_ram (
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.bus(map_bus.mem)
	);

	////////////////////////////////////////////////////////////////////////////
	// Filament on-count and pin configuration registers
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			filament_on_count_q <= `FIL_ON_RST;
		end else if (cmd_wr && cmd_reg == `REG_FILAMENT_DUTY) begin
			filament_on_count_q <= cmd_data_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			leg_a_cfg_q <= vfdom_pkg::vfdom_pin_mode_t'(`PIN_CFG_RST);
			leg_b_cfg_q <= vfdom_pkg::vfdom_pin_mode_t'(`PIN_CFG_RST);
		end else if (cmd_wr && cmd_reg == `REG_FIRST_PHASE_CFG) begin
			leg_a_cfg_q <= vfdom_pkg::vfdom_pin_mode_t'(cmd_data_in[1:0]);
		end else if (cmd_wr && cmd_reg == `REG_SECOND_PHASE_CFG) begin
			leg_b_cfg_q <= vfdom_pkg::vfdom_pin_mode_t'(cmd_data_in[1:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read answers, one cycle after the command; unmapped reads give zero
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= 8'h00;
		end else begin
			rd_valid_q <= cmd_rd;
			if (cmd_rd) begin
				case (cmd_reg)
					`REG_OUTPUT_MAP_PORT: rd_data_q <= {1'b0, map_bus.rd_data};
					`REG_FILAMENT_DUTY: rd_data_q <= filament_on_count_q;
					`REG_FIRST_PHASE_CFG: rd_data_q <= {6'h00, leg_a_cfg_q};
					`REG_SECOND_PHASE_CFG: rd_data_q <= {6'h00, leg_b_cfg_q};
					default: rd_data_q <= 8'h00;
				endcase
			end
		end
	end

	assign rd_valid_out = rd_valid_q;
	assign rd_data_out = rd_data_q;

	////////////////////////////////////////////////////////////////////////////
	// Waveform generator
	vfdom_fil_gen u_fil_gen (
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.on_count_in(filament_on_count_q),
		.leg_a_out(fil_a),
		.leg_b_out(fil_b)
	);

	// Pin drive per configuration
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			leg_a_q <= 1'b0;
			leg_b_q <= 1'b0;
		end else begin
			leg_a_q <= pin_level(leg_a_cfg_q, blink_phase_in, fil_a, shutdown_in);
			leg_b_q <= pin_level(leg_b_cfg_q, blink_phase_in, fil_b, shutdown_in);
		end
	end

	assign bridge_leg_a_out = leg_a_q;
	assign bridge_leg_b_out = leg_b_q;

	////////////////////////////////////////////////////////////////////////////
	// Lookup code and its class for the shifter
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			lk_code_q <= 7'h00;
			lk_grid_q <= 1'b0;
			lk_cursor_q <= 1'b0;
			lk_none_q <= 1'b0;
		end else begin
			lk_code_q <= map_bus.lk_data;
			lk_grid_q <= map_bus.lk_data <= `CODE_GRID_LAST;
			lk_cursor_q <= map_bus.lk_data == `CODE_CURSOR_LO || map_bus.lk_data == `CODE_CURSOR_HI;
			lk_none_q <= map_bus.lk_data >= `CODE_NONE_FIRST;
		end
	end

	assign map_lookup_code_out = lk_code_q;
	assign map_lookup_grid_out = lk_grid_q;
	assign map_lookup_cursor_out = lk_cursor_q;
	assign map_lookup_none_out = lk_none_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_ptr_load: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		map_ptr_load |=> ptr_q == $past(cmd_data_in[6:0]))
		else $error("pointer not loaded");
	chk_ptr_reset: assert property (@(posedge ref_clk_in)
		$past(!rstn_in) && rstn_in |-> ptr_q == 7'h00)
		else $error("pointer not zero after reset");
	chk_write_adv: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		map_wr && ptr_q < `MAP_LAST |=> ptr_q == 7'($past(ptr_q) + 7'h01) &&
		u_map_ram.mem_q[$past(ptr_q)] == $past(cmd_data_in[6:0]))
		else $error("map write or advance wrong");
	chk_read_answer: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		map_rd |=> rd_valid_out && rd_data_out == {1'b0, $past(map_bus.rd_data)} && ptr_q != $past(ptr_q))
		else $error("map read answer wrong");
	chk_ptr_wrap: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		(map_wr || map_rd) && ptr_q == `MAP_LAST |=> ptr_q == 7'h00)
		else $error("pointer did not wrap");
	chk_duty_write: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		cmd_wr && cmd_reg == `REG_FILAMENT_DUTY |=> filament_on_count_q == $past(cmd_data_in))
		else $error("on-count not stored");
	chk_static_pin: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		leg_a_cfg_q == vfdom_pkg::PIN_HIGH ##1 leg_a_cfg_q == vfdom_pkg::PIN_HIGH |-> bridge_leg_a_out)
		else $error("leg A static level wrong");
	chk_blink_pin: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		leg_a_cfg_q == vfdom_pkg::PIN_BLINK |=> bridge_leg_a_out == $past(blink_phase_in))
		else $error("blink phase not shown");
	chk_shutdown_low: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		shutdown_in && leg_a_cfg_q == vfdom_pkg::PIN_FILAMENT |=> !bridge_leg_a_out)
		else $error("leg A driven in shutdown");
	chk_leg_b_wave: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		leg_b_cfg_q == vfdom_pkg::PIN_FILAMENT |=> bridge_leg_b_out == ($past(fil_b) && !$past(shutdown_in)))
		else $error("leg B waveform wrong");
	chk_lookup_class: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		1'b1 |=> map_lookup_none_out == ($past(map_bus.lk_data) >= `CODE_NONE_FIRST) &&
		map_lookup_grid_out == ($past(map_bus.lk_data) < 7'h30))
		else $error("lookup class wrong");
	cov_ptr_wrap: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) map_wr && ptr_q == `MAP_LAST);
	cov_map_read: cover property (@(posedge ref_clk_in) disable iff (!rstn_in) map_rd ##1 map_rd);
	cov_fil_shutdown: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
		leg_a_cfg_q == vfdom_pkg::PIN_FILAMENT && shutdown_in && fil_a);
endmodule

/* bench/vfdom_host.sv */
// Host model that issues command bytes to the device and collects read answers
`timescale 1ns/1ps
module vfdom_host (
	// Clock
	input logic ref_clk_in,
	// Command port towards the device
	output logic cmd_valid_out,
	output logic [7:0] cmd_addr_out,
	output logic [7:0] cmd_data_out,
	// Read answer from the device
	input logic rd_valid_in,
	input logic [7:0] rd_data_in
);
	////////////////////////////////////////////////////////////////////////////////
	// Idle bus at time zero
	initial begin
		cmd_valid_out = 1'b0;
		cmd_addr_out = 8'h00;
		cmd_data_out = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One command byte, held for exactly one taking edge
	task automatic send(input logic [7:0] addr, input logic [7:0] data);
		@(posedge ref_clk_in);
		#1;
		cmd_valid_out = 1'b1;
		cmd_addr_out = addr;
		cmd_data_out = data;
		@(posedge ref_clk_in);
		#1;
		cmd_valid_out = 1'b0;
		cmd_addr_out = ~addr; // Released lines must not keep the old value
		cmd_data_out = ~data;
	endtask

	// Read command, waits a few cycles for the answer
	task automatic fetch(input logic [7:0] addr, output logic [7:0] data, output bit ok);
		int i;
		send(addr, 8'h00);
		ok = 1'b0;
		data = 8'h00;
		for (i = 0; i < 4 && !ok; i++) begin
			if (rd_valid_in === 1'b1) begin
				data = rd_data_in;
				ok = 1'b1;
			end else begin
				@(posedge ref_clk_in);
				#1;
			end
		end
	endtask

	// Pointer load carries the flag in bit 7
	task automatic set_ptr(input logic [6:0] ptr);
		send(8'h06, {1'b1, ptr});
	endtask

	// On-count kept inside its legal range before it is sent
	task automatic set_duty(input logic [7:0] n);
		send(8'h09, (n < 8'h01) ? 8'h01 : (n > 8'hC7) ? 8'hC7 : n);
	endtask
endmodule

/* bench/vfdom_top_tb.sv */
// Self-checking bench for the output map port and the filament bridge pins
`timescale 1ns/1ps
module vfdom_top_tb;
	logic ref_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic cmd_valid, rd_valid, lk_grid, lk_cursor, lk_none, leg_a, leg_b;
	logic [7:0] cmd_addr, cmd_data, rd_data;
	logic shutdown = 1'b0;
	logic blink = 1'b0;
	logic [6:0] lk_addr = 7'h00;
	logic [6:0] lk_code;
	int n_fail = 0;
	int n_tests = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and instances
	always #10 ref_clk_in = ~ref_clk_in;

	vfdom_top u_vfdom_top (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .cmd_valid_in(cmd_valid),
		.cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data), .rd_valid_out(rd_valid), .rd_data_out(rd_data),
		.shutdown_in(shutdown), .blink_phase_in(blink), .map_lookup_addr_in(lk_addr),
		.map_lookup_code_out(lk_code), .map_lookup_grid_out(lk_grid), .map_lookup_cursor_out(lk_cursor),
		.map_lookup_none_out(lk_none), .bridge_leg_a_out(leg_a), .bridge_leg_b_out(leg_b));

	vfdom_host u_vfdom_host (.ref_clk_in(ref_clk_in), .cmd_valid_out(cmd_valid), .cmd_addr_out(cmd_addr),
		.cmd_data_out(cmd_data), .rd_valid_in(rd_valid), .rd_data_in(rd_data));

	////////////////////////////////////////////////////////////////////////////////
	// Expected power-up code of a map location
	function automatic logic [6:0] exp_init(input int a);
		if (a <= 'h27) return 7'(a);
		if (a <= 'h6F) return 7'(a + 8);
		if (a == 'h70) return 7'h7C;
		if (a == 'h71) return 7'h7D;
		return 7'h7F;
	endfunction

	// Verdict and end of run
	task automatic print_verdict();
		if (n_fail == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// Value comparison
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Length comparison, expected given in half clocks, one clock of slack for tick jitter
	task automatic chk_len(input string what, input int exp2, input int got);
		n_tests++;
		if (2 * got - exp2 > 2 || exp2 - 2 * got > 2) begin
			n_fail++;
			$display("Error %s expected %0d seen %0d", what, exp2 / 2, got);
		end
	endtask

	// Settled sampling point after a clock edge
	task automatic tick();
		@(posedge ref_clk_in);
		#1;
	endtask

	// Read with a bounded wait
	task automatic rd(input logic [7:0] addr, output logic [7:0] d);
		bit ok;
		u_vfdom_host.fetch(addr, d, ok);
		if (!ok) begin
			n_fail++;
			print_verdict();
		end
	endtask

	// Measures one filament period from the rise of leg B, loading the next on-count meanwhile
	task automatic measure(input bit fresh, input logic [7:0] n_old, input logic [7:0] n_new);
		int i, hb, gap, ha, lo;
		hb = 0;
		gap = 0;
		ha = 0;
		lo = 0;
		for (i = 0; fresh && i < 6000 && leg_b !== 1'b0; i++) tick();
		for (i = 0; i < 6000 && leg_b !== 1'b1; i++) tick();
		if (n_new != n_old) fork u_vfdom_host.set_duty(n_new); join_none
		while (leg_b === 1'b1 && hb < 6000) begin hb++; tick(); end
		while (leg_a !== 1'b1 && gap < 6000) begin gap++; tick(); end
		while (leg_a === 1'b1 && ha < 6000) begin ha++; tick(); end
		while (leg_b !== 1'b1 && lo < 6000) begin lo++; tick(); end
		if (lo >= 6000) begin n_fail++; print_verdict(); end
		chk_len("leg_b_high", 25 * n_old, hb);
		chk_len("dead_time", 50, gap);
		chk_len("leg_a_high", 25 * n_old, ha);
		chk_len("both_low", 25 * (398 - n_old - n_new), lo);
		chk_len("period", 25 * (400 + n_old - n_new), hb + gap + ha + lo);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0] d;
		logic [6:0] e, p;
		logic [6:0] v [8];
		logic [7:0] nl [5];
		logic seen;
		int a, r, k, leg, code, bl;
		void'($urandom(87279));
		repeat (20) @(posedge ref_clk_in);
		#1;
		rstn_in = 1'b1;
		// Reset values of the registers and an unmapped read
		chk8("leg_pins_reset", 8'h00, {6'h00, leg_a, leg_b});
		for (a = 0; a < 4; a++) begin
			rd(8'h8B - 8'(a), d);
			chk8("reg_reset", (a == 2) ? 8'h01 : 8'h00, d);
		end
		// Power-up map contents streamed from pointer zero, with wrap, and the lookup port
		for (a = 0; a <= 'h7A; a++) begin
			lk_addr = 7'(a % 'h7A);
			rd(8'h86, d);
			e = exp_init(a % 'h7A);
			chk8("map_init", {1'b0, e}, d);
			chk8("lookup_code", {1'b0, e}, {1'b0, lk_code});
			chk8("lookup_flags", {5'h00, e <= 7'h2F, e == 7'h7C || e == 7'h7D, e >= 7'h7E},
				{5'h00, lk_grid, lk_cursor, lk_none});
		end
		// Pointer load, streamed writes and read back, top location first then a random one
		for (r = 0; r < 2; r++) begin
			p = (r == 0) ? 7'h79 : 7'($urandom_range(0, 'h79));
			u_vfdom_host.set_ptr(p);
			for (k = 0; k < 8; k++) begin
				v[k] = 7'($urandom_range(0, 127));
				u_vfdom_host.send(8'h06, {1'b0, v[k]});
			end
			u_vfdom_host.set_ptr(p);
			for (k = 0; k < 8; k++) begin
				rd(8'h86, d);
				chk8("map_rw", {1'b0, v[k]}, d);
			end
		end
		// Static and blink modes of both leg pins, with read back of the codes
		for (leg = 0; leg < 2; leg++) for (code = 0; code < 3; code++) for (bl = 0; bl < 2; bl++) begin
			blink = bl[0];
			u_vfdom_host.send(8'h0A + 8'(leg), 8'(code));
			tick();
			tick();
			chk8("pin_level", (code == 0) ? 8'h00 : (code == 1) ? 8'h01 : 8'(bl),
				{7'h00, (leg == 0) ? leg_a : leg_b});
			rd(8'h8A + 8'(leg), d);
			chk8("pin_config", 8'(code), d);
		end
		// Filament waveform over a list of on-counts, all but the first loaded in mid-period
		u_vfdom_host.send(8'h0A, 8'h03);
		u_vfdom_host.send(8'h0B, 8'h03);
		nl = '{8'h01, 8'hC7, 8'h64, 8'hC6, 8'($urandom_range(1, 199))};
		u_vfdom_host.set_duty(nl[0]);
		rd(8'h89, d);
		chk8("duty_readback", nl[0], d);
		repeat (5100) tick();
		for (k = 0; k < 5; k++) measure(k == 0, nl[k], nl[(k < 4) ? k + 1 : 4]);
		// Shutdown forces both filament legs low for a whole period
		shutdown = 1'b1;
		tick();
		tick();
		seen = 1'b0;
		for (k = 0; k < 5000; k++) begin
			seen = seen | leg_a | leg_b;
			tick();
		end
		chk8("legs_in_shutdown", 8'h00, {7'h00, seen});
		print_verdict();
	end
endmodule
